// ### pmt_pkg.sv
// package: constants for the power management timer block
`default_nettype none

package pmt_pkg;

  // ---------------------------------------------------------------
  // register offsets from the I/O base
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_ENABLE = 4'h2;
  localparam logic [3:0] OFS_CTL_TWO = 4'h5;
  localparam logic [3:0] OFS_CTL_THREE = 4'h6;
  localparam logic [3:0] OFS_CTL_FOUR = 4'h7;
  localparam logic [3:0] OFS_CNT_LOW = 4'h8;
  localparam logic [3:0] OFS_CNT_MID = 4'h9;
  localparam logic [3:0] OFS_CNT_HIGH = 4'ha;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int FLAG_BIT = 0;
  localparam int ENABLE_BIT = 0;
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_RST = 24'h00_0000;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] RSVD_VALUE = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int REF_CLK_HZ = 3_579_545;
  // system clocks per reference period, rounded down
  localparam int REF_PERIOD_CYC = SYS_CLK_HZ / REF_CLK_HZ;

endpackage : pmt_pkg

`default_nettype wire

// ### pmt_cnt_if.sv
// interface: link between timer control and the count register
`default_nettype none

interface pmt_cnt_if;
  logic advance;
  logic [pmt_pkg::CNT_W-1:0] count;
  logic carry_pulse;

  modport ctrl (
    output advance,
    input count,
    input carry_pulse
  );

  modport cnt (
    input advance,
    output count,
    output carry_pulse
  );
endinterface : pmt_cnt_if

`default_nettype wire

// ### pmt_counter.sv
// module: 24-bit power management count register with carry detect
`default_nettype none

module pmt_counter (
  input wire logic clk_i,
  input wire logic rst_n_i,
  pmt_cnt_if.cnt cnt_if
);

  logic [pmt_pkg::CNT_W-1:0] count_q;
  logic [pmt_pkg::CNT_W-1:0] count_d;
  logic carry_q;
  logic carry_d;

  // ---------------------------------------------------------------
  // next count
  // ---------------------------------------------------------------
  always_comb begin
    count_d = count_q;
    if (cnt_if.advance) begin
      // wraps from all ones back to zero
      count_d = count_q + 24'h00_0001;
    end
    // no advance: value held, no reload on restart
    // top bit toggling in either direction is a carry event
    carry_d = count_d[pmt_pkg::CNT_W-1] ^ count_q[pmt_pkg::CNT_W-1];
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_q <= pmt_pkg::CNT_RST;
      carry_q <= 1'b0;
    end else begin
      count_q <= count_d;
      carry_q <= carry_d;
    end
  end

  assign cnt_if.count = count_q;
  assign cnt_if.carry_pulse = carry_q;

endmodule : pmt_counter

`default_nettype wire

// ### pmt_timer.sv
// module: power management timer with its I/O-space register file
`default_nettype none

module pmt_timer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reference_clock_input_i,
  input wire logic working_state_i,
  input wire logic [3:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic sci_n_o,
  output logic count_carry_flag_o
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [3:0] addr,
                               input logic [3:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  pmt_cnt_if cnt_if ();

  pmt_counter u_counter (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cnt_if(cnt_if)
  );

  logic ref_prev_q;
  logic ref_prev_d;
  logic flag_q;
  logic flag_d;
  logic enable_q;
  logic enable_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic sci_n_q;
  logic sci_n_d;
  logic clear_flag;

  // ---------------------------------------------------------------
  // reference clock edge and count enable
  // ---------------------------------------------------------------
  always_comb begin
    ref_prev_d = reference_clock_input_i;
    // one advance per rising edge, only in working state
    cnt_if.advance = reference_clock_input_i & ~ref_prev_q &
                     working_state_i;
  end

  // ---------------------------------------------------------------
  // status, enable and interrupt
  // ---------------------------------------------------------------
  always_comb begin
    clear_flag = io_wr_i & hit(io_addr_i, pmt_pkg::OFS_STATUS) &
                 io_wdata_i[pmt_pkg::FLAG_BIT];
    // a carry in the clearing cycle wins over the clear
    flag_d = cnt_if.carry_pulse | (flag_q & ~clear_flag);
    enable_d = enable_q;
    if (io_wr_i && hit(io_addr_i, pmt_pkg::OFS_ENABLE)) begin
      enable_d = io_wdata_i[pmt_pkg::ENABLE_BIT];
    end
    sci_n_d = ~(flag_d & enable_d);
  end

  // ---------------------------------------------------------------
  // read data; count bytes are taken from a single-domain register
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    if (io_rd_i) begin
      rdata_d = pmt_pkg::RSVD_VALUE;
      if (hit(io_addr_i, pmt_pkg::OFS_STATUS)) begin
        rdata_d[pmt_pkg::FLAG_BIT] = flag_q;
      end else if (hit(io_addr_i, pmt_pkg::OFS_ENABLE)) begin
        rdata_d[pmt_pkg::ENABLE_BIT] = enable_q;
      end else if (hit(io_addr_i, pmt_pkg::OFS_CNT_LOW)) begin
        rdata_d = cnt_if.count[7:0];
      end else if (hit(io_addr_i, pmt_pkg::OFS_CNT_MID)) begin
        rdata_d = cnt_if.count[15:8];
      end else if (hit(io_addr_i, pmt_pkg::OFS_CNT_HIGH)) begin
        rdata_d = cnt_if.count[23:16];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ref_prev_q <= 1'b0;
      flag_q <= 1'b0;
      enable_q <= 1'b0;
      rdata_q <= pmt_pkg::REG_RST;
      sci_n_q <= 1'b1;
    end else begin
      ref_prev_q <= ref_prev_d;
      flag_q <= flag_d;
      enable_q <= enable_d;
      rdata_q <= rdata_d;
      sci_n_q <= sci_n_d;
    end
  end

  assign io_rdata_o = rdata_q;
  assign sci_n_o = sci_n_q;
  assign count_carry_flag_o = flag_q;

endmodule : pmt_timer

`default_nettype wire

// ### pmt_checker.sv
// checker: port assertions of the power management timer
`default_nettype none
module pmt_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reference_clock_input_i,
  input wire logic working_state_i,
  input wire logic [3:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic sci_n_o,
  input wire logic count_carry_flag_o
);
  wire logic en_wr = io_wr_i && io_addr_i == 4'h2;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  reset_state_a: assert property (disable iff (1'b0) !rst_n_i |=>
    io_rdata_o == 8'h00 && sci_n_o && !count_carry_flag_o) else $error("rst");
  reserved_zero_a: assert property (io_rd_i &&
    io_addr_i inside {[4'h5:4'h7]} |=> io_rdata_o == 8'h00) else $error("rsvd");
  read_hold_a: assert property (!io_rd_i |=> $stable(io_rdata_o))
    else $error("rdata moved");
  flag_keep_a: assert property (count_carry_flag_o && !(io_wr_i &&
    io_addr_i == 4'h0 && io_wdata_i[0]) |=> count_carry_flag_o) else $error("f");
  idle_no_carry_a: assert property (!working_state_i [*5] |->
    !$rose(count_carry_flag_o)) else $error("carry while idle");
  sci_flag_a: assert property (!sci_n_o |-> count_carry_flag_o)
    else $error("sci without flag");
  enable_on_a: assert property (en_wr && io_wdata_i[0] &&
    count_carry_flag_o |=> !sci_n_o) else $error("sci missing");
  enable_off_a: assert property (en_wr && !io_wdata_i[0] |=> sci_n_o)
    else $error("sci while disabled");
endmodule : pmt_checker
bind pmt_timer pmt_checker u_chk (.*);
`default_nettype wire

// ### pmt_host.sv
// partner: host issuing I/O-space register cycles
`default_nettype none
module pmt_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [3:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {addr_o, wdata_o, rd_o, wr_o} = 14'h0000;
  // one-cycle strobe; released address and data show their inverse, both strobes drop to zero
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v,
    output logic [7:0] d);
    @(posedge clk_i);
    #1 {addr_o, wdata_o, rd_o, wr_o} = {a, v, !w, w};
    @(posedge clk_i);
    #1 {addr_o, wdata_o, rd_o, wr_o} = {~a, ~v, 2'b00};
    d = rdata_i;
  endtask : bus
endmodule : pmt_host
`default_nettype wire

// ### pmt_timer_bench.sv
// bench: self-checking test of the power management timer
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module pmt_timer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_n_i = 1'b0, reference_clock_input_i = 1'b0;
  logic working_state_i = 1'b1, io_rd_i, io_wr_i, sci_n_o, count_carry_flag_o;
  logic [3:0] io_addr_i, rsv[5] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'hf};
  logic [7:0] io_wdata_i, io_rdata_o, d, v;
  logic [23:0] cnt;
  int err_total = 0, tests_run = 0, cyc = 0;
  always #5 clk_i = ~clk_i;
  pmt_timer DUT (.*);
  pmt_host host (.clk_i(clk_i), .rdata_i(io_rdata_o), .addr_o(io_addr_i),
    .rd_o(io_rd_i), .wr_o(io_wr_i), .wdata_o(io_wdata_i));
  function automatic logic [23:0] adv(logic [23:0] c, int k, logic w);
    return w ? c + 24'(k) : c;
  endfunction : adv
  task automatic rd(input logic [3:0] a);
    host.bus(1'b0, a, 8'h00, d);
  endtask : rd
  task automatic pulse(input int k, input logic w);
    working_state_i = w;
    repeat (2 * k) begin
      @(posedge clk_i);
      #1 reference_clock_input_i = ~reference_clock_input_i;
    end
    cnt = adv(cnt, k, w);
  endtask : pulse
  task automatic restart();
    rst_n_i = 1'b0;
    repeat (6) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    cnt = 24'h0;
  endtask : restart
  task automatic report_and_stop();
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  always @(posedge clk_i) if (++cyc == 5000) begin
    err_total++;
    report_and_stop();
  end
  initial begin
    void'($urandom(48));
    restart();
    rd(4'h8);
    `CHK("count low", cnt[7:0], d)
    pulse(int'(250 + $urandom % 20), 1'b1);
    rd(4'h8);
    `CHK("count low", cnt[7:0], d)
    foreach (rsv[i]) begin
      v = 8'($urandom);
      host.bus(1'b1, rsv[i], v, d);
      rd(rsv[i]);
      `CHK("write ignored", (rsv[i] == 4'h8) ? cnt[7:0] : 8'h00, d)
    end
    pulse(7, 1'b0);
    rd(4'h8);
    `CHK("count idle", cnt[7:0], d)
    working_state_i = 1'b1;
    repeat (30) @(posedge clk_i);
    rd(4'h8);
    `CHK("count stopped", cnt[7:0], d)
    pulse(5, 1'b1);
    rd(4'h8);
    `CHK("count resumed", cnt[7:0], d)
    rd(4'h9);
    `CHK("count mid", cnt[15:8], d)
    rd(4'h0);
    `CHK("carry status", 8'h00, d)
    `CHK("carry flag", 1'b0, count_carry_flag_o)
    for (int i = 0; i < 2; i++) begin
      v = {7'($urandom), i[0]};
      host.bus(1'b1, 4'h2, v, d);
      rd(4'h2);
      `CHK("carry enable", v[0], d[0])
    end
    `CHK("sci without carry", 1'b1, sci_n_o)
    restart();
    rd(4'h8);
    `CHK("count cleared", 8'h00, d)
    pulse(3, 1'b1);
    rd(4'h8);
    `CHK("count restart", cnt[7:0], d)
    report_and_stop();
  end
endmodule : pmt_timer_bench
`default_nettype wire
